// [core/scc_consts.vh]
// Constants for the system channel and scan controller
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH
`define SCC_FUNC_W 3
`define SCC_FUNC_DCV 3'h0
`define SCC_FUNC_ACV 3'h1
`define SCC_FUNC_DCI 3'h2
`define SCC_FUNC_ACI 3'h3
`define SCC_FUNC_RES2 3'h4
`define SCC_FUNC_RES4 3'h5
`define SCC_FUNC_OTHER 3'h6
`define SCC_CH_W 5
`define SCC_CH_NONE 5'h00
`define SCC_CH_PAIR_LO 5'h01
`define SCC_CH_PAIR_HI 5'h0a
`define SCC_CH_PAIR_OFS 5'h0a
`define SCC_CH_MUX_MAX 5'h14
`define SCC_CH_AMP_A 5'h15
`define SCC_CH_AMP_B 5'h16
`define SCC_SLOT_W 4
`define SCC_TEN_MIN 5'h0a
`define SCC_TWENTY_MIN 5'h14
`define SCC_BCD_ONE 4'h1
`define SCC_BCD_TWO 4'h2
`define SCC_CNT_W 14
`define SCC_CNT_MAX 14'h2af8
`define SCC_CNT_ONE 14'h0001
`define SCC_TRIG_RST 14'h0001
`define SCC_ST_IDLE 3'h0
`define SCC_ST_SETTLE 3'h1
`define SCC_ST_READ 3'h2
`define SCC_ST_WAIT 3'h3
`define SCC_ST_NEXT 3'h4
`define SCC_ST_PASS 3'h5
`endif

// [core/scc_chan_check.v]
// Channel validity check against the selected function
`timescale 1ns/100ps
`default_nettype none
`include "scc_consts.vh"
module scc_chan_check (
  input wire [2:0] func,
  input wire [4:0] chan,
  output wire valid
);
  wire is_amp_func;
  wire is_amp_chan;
  wire is_mux_chan;
  assign is_amp_func = (func == `SCC_FUNC_DCI) || (func == `SCC_FUNC_ACI);
  assign is_amp_chan = (chan == `SCC_CH_AMP_A) || (chan == `SCC_CH_AMP_B);
  assign is_mux_chan = (chan != `SCC_CH_NONE) && (chan <= `SCC_CH_MUX_MAX);
  // 4-wire uses only the primary channels of a pair
  assign valid = is_amp_func ? is_amp_chan :
    ((func == `SCC_FUNC_RES4) ? ((chan >= `SCC_CH_PAIR_LO) && (chan <= `SCC_CH_PAIR_HI)) :
    is_mux_chan);
endmodule // scc_chan_check
`default_nettype wire

// [core/scc_top.v]
// System channel close/open control and simple scan sequencer
// Functional notes
// - Closing a channel first opens any previously closed channel or pair.
// - Closed channel shown as slot digit plus two-digit channel number.
// - In 4-wire mode only the primary channel number is indicated.
// - Current functions may close only channels 21 and 22.
// - Channels 21 and 22 are refused under any non-current function.
// - Each close request carries exactly one channel.
// - Closed-channel query returns only the primary channel code.
// - Switching to 4-wire sets the indicator and adds the pair of a closed channel 1 to 10.
// - Scan steps only through list channels valid for the function.
// - Reading count sets stored readings; in step mode also channels visited, but no more than one list per trigger.
// - Scan mode passes equal reading count over list length, rounded up.
// - Step mode waits the interval between successive channels.
// - Scan mode interval starts with the pass; next pass waits for it.
// - Trigger count accepted from 1 to 11000, or infinite.
// - Sample count accepted from 1 to 11000.
// - Sweep list selector internal enables scanning, none disables it.
// - Default restore opens all, selects DC volts, trigger count one.
// - Scanning begins only on initiate with the list enabled.
// - Halt or selector none stops the scanner.
// - 4-wire pairs channels 1 to 10 with 11 to 20 for sense.
`timescale 1ns/100ps
`default_nettype none
`include "scc_consts.vh"
module scc_top #(
  parameter SLOT = 4'h1,
  parameter SETTLE_CYC = 4,
  parameter TICK_DIV = 40000
) (
  input wire clk,
  input wire rst,
  input wire close_req,
  input wire [4:0] close_chan,
  input wire [1:0] close_chan_count,
  input wire open_all,
  input wire default_restore,
  input wire func_set,
  input wire [2:0] func_sel,
  input wire query_req,
  input wire trig_count_set,
  input wire [13:0] trig_count_val,
  input wire trig_count_inf,
  input wire samp_count_set,
  input wire [13:0] samp_count_val,
  input wire reading_count_set,
  input wire [13:0] reading_count_setting,
  input wire step_mode,
  input wire [4:0] list_min,
  input wire [4:0] list_max,
  input wire [15:0] interval_ticks,
  input wire sweep_list_selector,
  input wire initiate,
  input wire halt,
  output reg [4:0] input_chan_q,
  output reg [4:0] sense_chan_q,
  output reg four_wire_indicator,
  output reg [11:0] disp_code_q,
  output reg query_valid_q,
  output reg [11:0] query_code_q,
  output reg err_q,
  output reg [2:0] func_q,
  output reg [13:0] trig_count_q,
  output reg trig_inf_q,
  output reg [13:0] samp_count_q,
  output reg [13:0] rdg_count_q,
  output reg scanning_q,
  output reg reading_strobe_q,
  output reg [13:0] stored_q
);
  // ****************************************
  // Timing limits
  // ****************************************
  localparam [7:0] SETTLE_LIM = SETTLE_CYC;
  localparam [15:0] TICK_LAST = TICK_DIV - 1;
  // ****************************************
  // Channel selection
  // ****************************************
  wire req_valid;
  wire scan_valid;
  reg [4:0] scan_chan_q;
  reg [2:0] st_q;
  wire in_range_trig;
  wire in_range_samp;
  wire [3:0] tens;
  wire [3:0] ones;
  wire [7:0] bcd_w;
  wire list_ok;
  wire range_rdg;
  wire rdg_live;
  scc_chan_check u_req_chk (
    .func(func_q),
    .chan(close_chan),
    .valid(req_valid)
  );
  scc_chan_check u_scan_chk (
    .func(func_q),
    .chan(scan_chan_q),
    .valid(scan_valid)
  );
  // Pair partner for a 4-wire primary
  function [4:0] pair_of;
    input [2:0] f;
    input [4:0] c;
    begin
      if ((f == `SCC_FUNC_RES4) && (c >= `SCC_CH_PAIR_LO) && (c <= `SCC_CH_PAIR_HI)) begin
        pair_of = c + `SCC_CH_PAIR_OFS;
      end else begin
        pair_of = `SCC_CH_NONE;
      end
    end
  endfunction
  assign in_range_trig = (trig_count_val >= `SCC_CNT_ONE) && (trig_count_val <= `SCC_CNT_MAX);
  assign in_range_samp = (samp_count_val >= `SCC_CNT_ONE) && (samp_count_val <= `SCC_CNT_MAX);
  // ****************************************
  // Display and query code
  // ****************************************
  // Two BCD digits of a module channel number
  function [7:0] chan_bcd;
    input [4:0] c;
    reg [4:0] rem;
    begin
      if (c >= `SCC_TWENTY_MIN) begin
        rem = c - `SCC_TWENTY_MIN;
        chan_bcd = {`SCC_BCD_TWO, rem[3:0]};
      end else if (c >= `SCC_TEN_MIN) begin
        rem = c - `SCC_TEN_MIN;
        chan_bcd = {`SCC_BCD_ONE, rem[3:0]};
      end else begin
        rem = c;
        chan_bcd = {4'h0, rem[3:0]};
      end
    end
  endfunction
  // Code always from the primary channel only
  assign bcd_w = chan_bcd(input_chan_q);
  assign tens = bcd_w[7:4];
  assign ones = bcd_w[3:0];
  // ****************************************
  // Scan sequencer
  // ****************************************
  reg [15:0] tick_q;
  reg [15:0] ivl_q;
  reg [13:0] rdg_left_q;
  reg [13:0] trig_left_q;
  reg [7:0] settle_q;
  wire tick;
  wire ivl_done;
  wire scan_en;
  assign tick = (tick_q == TICK_LAST);
  assign ivl_done = (ivl_q == 16'h0000);
  assign scan_en = sweep_list_selector & ~halt;
  // Range and count qualifiers
  assign list_ok = (list_min <= list_max);
  assign range_rdg = (reading_count_setting >= `SCC_CNT_ONE) && (reading_count_setting <= `SCC_CNT_MAX);
  assign rdg_live = (rdg_left_q != 14'h0000);
  // ****************************************
  // Channel state and sequencer registers
  // ****************************************
  always @(posedge clk) begin
    if (rst || default_restore) begin
      input_chan_q <= `SCC_CH_NONE;
      sense_chan_q <= `SCC_CH_NONE;
      four_wire_indicator <= 1'b0;
      func_q <= `SCC_FUNC_DCV;
      trig_count_q <= `SCC_TRIG_RST;
      trig_inf_q <= 1'b0;
      samp_count_q <= `SCC_CNT_ONE;
      rdg_count_q <= `SCC_CNT_ONE;
      err_q <= 1'b0;
      query_valid_q <= 1'b0;
      query_code_q <= 12'h000;
      disp_code_q <= 12'h000;
      scanning_q <= 1'b0;
      reading_strobe_q <= 1'b0;
      stored_q <= 14'h0000;
      st_q <= `SCC_ST_IDLE;
      scan_chan_q <= `SCC_CH_NONE;
      tick_q <= 16'h0000;
      ivl_q <= 16'h0000;
      rdg_left_q <= 14'h0000;
      trig_left_q <= 14'h0000;
      settle_q <= 8'h00;
    end else begin
      err_q <= 1'b0;
      query_valid_q <= 1'b0;
      reading_strobe_q <= 1'b0;
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
      if (tick && !ivl_done) begin
        ivl_q <= ivl_q - 16'h0001;
      end
      disp_code_q <= (input_chan_q == `SCC_CH_NONE) ? 12'h000 :
        {SLOT[3:0], tens, ones};
      if (query_req) begin
        query_valid_q <= 1'b1;
        query_code_q <= (input_chan_q == `SCC_CH_NONE) ? 12'h000 :
          {SLOT[3:0], tens, ones};
      end
      if (func_set) begin
        func_q <= func_sel;
        if (func_sel == `SCC_FUNC_RES4 && input_chan_q != `SCC_CH_NONE) begin
          sense_chan_q <= pair_of(func_sel, input_chan_q);
          four_wire_indicator <= 1'b1;
        end else begin
          sense_chan_q <= `SCC_CH_NONE;
          four_wire_indicator <= (func_sel == `SCC_FUNC_RES4);
        end
        if (input_chan_q == `SCC_CH_AMP_A || input_chan_q == `SCC_CH_AMP_B) begin
          if (func_sel != `SCC_FUNC_DCI && func_sel != `SCC_FUNC_ACI) begin
            input_chan_q <= `SCC_CH_NONE;
          end
        end
      end
      if (trig_count_set) begin
        // Infinite keeps the last finite count
        if (trig_count_inf) begin
          trig_inf_q <= 1'b1;
        end else if (in_range_trig) begin
          trig_inf_q <= 1'b0;
          trig_count_q <= trig_count_val;
        end else begin
          err_q <= 1'b1;
        end
      end
      if (samp_count_set) begin
        if (in_range_samp) begin
          samp_count_q <= samp_count_val;
        end else begin
          err_q <= 1'b1;
        end
      end
      if (reading_count_set) begin
        if (range_rdg) begin
          rdg_count_q <= reading_count_setting;
        end else begin
          err_q <= 1'b1;
        end
      end
      // Open all wins over a close in the same cycle
      if (open_all) begin
        input_chan_q <= `SCC_CH_NONE;
        sense_chan_q <= `SCC_CH_NONE;
      end else if (close_req && st_q == `SCC_ST_IDLE) begin
        if (close_chan_count == 2'h1 && req_valid) begin
          input_chan_q <= close_chan;
          sense_chan_q <= pair_of(func_q, close_chan);
        end else begin
          err_q <= 1'b1;
        end
      end
      case (st_q)
        `SCC_ST_IDLE: begin
          scanning_q <= 1'b0;
          // Start needs the list enabled and a sane range
          if (initiate && sweep_list_selector && !halt && list_ok) begin
            scanning_q <= 1'b1;
            stored_q <= 14'h0000;
            rdg_left_q <= rdg_count_q;
            trig_left_q <= trig_count_q;
            scan_chan_q <= list_min;
            ivl_q <= interval_ticks;
            settle_q <= 8'h00;
            st_q <= `SCC_ST_SETTLE;
          end
        end
        `SCC_ST_SETTLE: begin
          // Skip channels the function cannot use
          if (!scan_valid) begin
            st_q <= `SCC_ST_NEXT;
          end else begin
            input_chan_q <= scan_chan_q;
            sense_chan_q <= pair_of(func_q, scan_chan_q);
            settle_q <= settle_q + 8'h01;
            if (settle_q == SETTLE_LIM) begin
              st_q <= `SCC_ST_READ;
            end
          end
        end
        `SCC_ST_READ: begin
          reading_strobe_q <= 1'b1;
          // Readings past the count finish the pass but are not stored
          if (rdg_live) begin
            stored_q <= stored_q + 14'h0001;
            rdg_left_q <= rdg_left_q - 14'h0001;
          end
          if (step_mode) begin
            ivl_q <= interval_ticks;
            st_q <= `SCC_ST_WAIT;
          end else begin
            st_q <= `SCC_ST_NEXT;
          end
        end
        `SCC_ST_WAIT: begin
          // Step delay between channels
          if (ivl_done) begin
            st_q <= `SCC_ST_NEXT;
          end
        end
        `SCC_ST_NEXT: begin
          settle_q <= 8'h00;
          // Step mode stops at the reading count
          if (!rdg_live && step_mode) begin
            st_q <= `SCC_ST_PASS;
          end else if (scan_chan_q >= list_max) begin
            scan_chan_q <= list_min;
            st_q <= `SCC_ST_PASS;
          end else begin
            scan_chan_q <= scan_chan_q + 5'h01;
            st_q <= `SCC_ST_SETTLE;
          end
        end
        `SCC_ST_PASS: begin
          // Scan mode always completes a pass, so count rounds up
          if (rdg_live && !step_mode) begin
            if (ivl_done) begin
              ivl_q <= interval_ticks;
              st_q <= `SCC_ST_SETTLE;
            end
          end else if (trig_inf_q || trig_left_q > `SCC_CNT_ONE) begin
            if (ivl_done) begin
              trig_left_q <= trig_left_q - 14'h0001;
              rdg_left_q <= rdg_count_q;
              scan_chan_q <= list_min;
              ivl_q <= interval_ticks;
              st_q <= `SCC_ST_SETTLE;
            end
          end else begin
            st_q <= `SCC_ST_IDLE;
          end
        end
        default: begin
          st_q <= `SCC_ST_IDLE;
        end
      endcase
      if (st_q != `SCC_ST_IDLE && !scan_en) begin
        st_q <= `SCC_ST_IDLE;
        scanning_q <= 1'b0;
      end
    end
  end
endmodule // scc_top
`default_nettype wire

// [verif/scc_host_model.sv]
// Host side: one-channel close lists, two-channel when multi, ascending scan range
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  input wire logic multi,
  input wire logic [4:0] lo,
  input wire logic [4:0] hi,
  output logic [1:0] close_chan_count,
  output logic [4:0] list_min,
  output logic [4:0] list_max
);
  // *****************
  // Host requests
  // *****************
  assign close_chan_count = multi ? 2'h2 : 2'h1;
  assign list_min = (lo < hi) ? lo : hi;
  assign list_max = (lo < hi) ? hi : lo;
endmodule // scc_host_model
`default_nettype wire

// [verif/scc_monitor.sv]
// Port checks of the channel and scan controller
`timescale 1ns/100ps
`default_nettype none
`include "scc_consts.vh"
module scc_monitor #(
  parameter SLOT = 4'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic close_req,
  input wire logic [4:0] close_chan,
  input wire logic [1:0] close_chan_count,
  input wire logic default_restore,
  input wire logic query_req,
  input wire logic trig_count_set,
  input wire logic [13:0] trig_count_val,
  input wire logic trig_count_inf,
  input wire logic sweep_list_selector,
  input wire logic initiate,
  input wire logic halt,
  input wire logic [4:0] input_chan_q,
  input wire logic [4:0] sense_chan_q,
  input wire logic four_wire_indicator,
  input wire logic query_valid_q,
  input wire logic [11:0] query_code_q,
  input wire logic err_q,
  input wire logic [2:0] func_q,
  input wire logic [13:0] trig_count_q,
  input wire logic scanning_q
);
  // *****************
  // Assertions
  // *****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    initiate && sweep_list_selector && !halt && !scanning_q;
  endsequence
  sequence s_stop;
    (halt || !sweep_list_selector) && scanning_q;
  endsequence
  sequence s_close;
    close_req && !scanning_q;
  endsequence
  a_scan_start: assert property (s_start |=> scanning_q) else $error("no start");
  a_scan_cause: assert property ($rose(scanning_q) |-> $past(initiate) && $past(sweep_list_selector))
    else $error("start without cause");
  a_halt_stop: assert property (s_stop |-> ##[1:2] !scanning_q) else $error("no halt");
  a_close_count: assert property (s_close ##0 (close_chan_count != 2'h1) |=> err_q)
    else $error("multi close taken");
  a_amp_current: assert property (s_close ##0 (close_chan_count == 2'h1
    && func_q == `SCC_FUNC_DCI && close_chan <= `SCC_CH_MUX_MAX) |=> err_q) else $error("mux on amps");
  a_amp_other: assert property (s_close ##0 (close_chan_count == 2'h1
    && func_q == `SCC_FUNC_DCV && close_chan == `SCC_CH_AMP_A)
    |=> err_q && input_chan_q == $past(input_chan_q)) else $error("amp on volts");
  a_pair_sense: assert property (four_wire_indicator && input_chan_q inside {[1:10]}
    |-> sense_chan_q == input_chan_q + `SCC_CH_PAIR_OFS) else $error("bad pair");
  a_query_resp: assert property (query_req |=> query_valid_q
    && ((query_code_q == 12'h000) == ($past(input_chan_q) == `SCC_CH_NONE)))
    else $error("no query answer");
  a_restore: assert property (default_restore |=> func_q == `SCC_FUNC_DCV
    && trig_count_q == `SCC_TRIG_RST && input_chan_q == `SCC_CH_NONE) else $error("bad restore");
  a_trig_range: assert property (trig_count_set && !trig_count_inf
    && trig_count_val > `SCC_CNT_MAX |=> err_q && $stable(trig_count_q)) else $error("bad trig");
endmodule // scc_monitor
bind scc_top scc_monitor #(.SLOT(SLOT)) mon (.*);
`default_nettype wire

// [verif/scc_top_tb_top.sv]
// Testbench of the channel and scan controller
`timescale 1ns/100ps
`default_nettype none
module scc_top_tb_top;
  // *****************
  // Bench
  // *****************
  logic clk = 0, rst = 1, close_req = 0, open_all = 0, default_restore = 0, func_set = 0;
  logic query_req = 0, trig_count_set = 0, trig_count_inf = 0, samp_count_set = 0, halt = 0;
  logic reading_count_set = 0, step_mode = 0, sweep_list_selector = 0, initiate = 0, multi = 0;
  logic [4:0] close_chan = 0, lo = 1, hi = 1, list_min, list_max, input_chan_q, sense_chan_q;
  logic [1:0] close_chan_count;
  logic [2:0] func_sel = 0, func_q;
  logic [13:0] trig_count_val = 1, samp_count_val = 1, reading_count_setting = 1;
  logic [13:0] trig_count_q, samp_count_q, rdg_count_q, stored_q;
  logic [15:0] interval_ticks = 1;
  logic [11:0] disp_code_q, query_code_q;
  logic four_wire_indicator, query_valid_q, err_q, trig_inf_q, scanning_q, reading_strobe_q;
  int error_cnt = 0, tests_run = 0, strobes = 0, cyc = 0, last = 0, maxgap = 0, n;
  always #12.5 clk = ~clk;
  scc_host_model host (.*);
  scc_top #(.TICK_DIV(4)) dut (.*);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (initiate === 1'b1) begin
      maxgap <= 0;
      last <= cyc;
    end else if (reading_strobe_q === 1'b1) begin
      strobes <= strobes + 1;
      last <= cyc;
      if (cyc - last > maxgap) maxgap <= cyc - last;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Strobe k with data v, return after the answering edge
  task pulse(input int k, input logic [13:0] v);
    @(posedge clk);
    close_chan <= v[4:0];
    func_sel <= v[2:0];
    trig_count_val <= v;
    samp_count_val <= v;
    reading_count_setting <= v;
    case (k)
      0: close_req <= 1;
      1: open_all <= 1;
      2: func_set <= 1;
      3: query_req <= 1;
      4: trig_count_set <= 1;
      5: samp_count_set <= 1;
      6: reading_count_set <= 1;
      7: initiate <= 1;
      default: default_restore <= 1;
    endcase
    @(posedge clk);
    {close_req, open_all, func_set, query_req, trig_count_set} <= 0;
    {samp_count_set, reading_count_set, initiate, default_restore} <= 0;
    #1;
  endtask
  task wait_idle;
    int i;
    for (i = 0; i < 3000 && scanning_q !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 3000) begin
      error_cnt++;
      close_out;
    end
    @(posedge clk);
    #1;
  endtask
  task t_close_seq;
    pulse(1, 0);
    pulse(2, 4);
    pulse(0, 1);
    chk(input_chan_q, 1);
    pulse(0, 6);
    chk(input_chan_q, 6);
    pulse(2, 5);
    chk(sense_chan_q, 16);
    chk(four_wire_indicator, 1);
    pulse(3, 0);
    chk(query_valid_q, 1);
    chk(query_code_q, 16'h0106);
    chk(disp_code_q, 16'h0106);
    pulse(1, 0);
    chk(input_chan_q, 0);
  endtask
  task t_amp;
    pulse(2, 0);
    pulse(0, 21);
    chk(err_q, 1);
    chk(input_chan_q, 0);
    pulse(2, 2);
    pulse(0, 5);
    chk(err_q, 1);
    pulse(0, 22);
    chk(input_chan_q, 22);
    pulse(2, 0);
    chk(input_chan_q, 0);
  endtask
  task t_refuse;
    @(posedge clk) multi <= 1;
    pulse(0, 3);
    chk(err_q, 1);
    chk(input_chan_q, 0);
    @(posedge clk) multi <= 0;
    pulse(4, 11000);
    chk(trig_count_q, 11000);
    pulse(4, 11001);
    chk(err_q, 1);
    chk(trig_count_q, 11000);
    @(posedge clk) trig_count_inf <= 1;
    pulse(4, 1);
    chk(trig_inf_q, 1);
    @(posedge clk) trig_count_inf <= 0;
    pulse(4, 1);
    pulse(5, 0);
    chk(err_q, 1);
    pulse(5, 11000);
    chk(samp_count_q, 11000);
  endtask
  task t_scan(input logic stp, input int rdg, input int exp, input int gap);
    @(posedge clk);
    lo <= 3;
    hi <= 1;
    step_mode <= stp;
    interval_ticks <= 20;
    pulse(6, rdg);
    n = strobes;
    pulse(7, 0);
    chk(scanning_q, 1);
    wait_idle;
    chk(strobes - n, exp);
    chk(stored_q, rdg);
    chk(rdg_count_q, rdg);
    chk(maxgap >= gap, 1);
  endtask
  task t_halt;
    pulse(7, 0);
    repeat (20) @(posedge clk);
    halt <= 1;
    repeat (3) @(posedge clk);
    #1;
    chk(scanning_q, 0);
    @(posedge clk) halt <= 0;
    pulse(7, 0);
    repeat (20) @(posedge clk);
    sweep_list_selector <= 0;
    repeat (3) @(posedge clk);
    #1;
    chk(scanning_q, 0);
  endtask
  task t_restore;
    pulse(2, 1);
    pulse(0, 4);
    pulse(4, 5);
    pulse(8, 0);
    chk(func_q, 0);
    chk(trig_count_q, 1);
    chk(input_chan_q, 0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_close_seq;
    t_amp;
    t_refuse;
    pulse(7, 0);
    chk(scanning_q, 0);
    @(posedge clk) sweep_list_selector <= 1;
    t_scan(1, 2, 2, 80);
    chk(stored_q, 2);
    t_scan(0, 4, 6, 40);
    pulse(6, 100);
    t_halt;
    t_restore;
    close_out;
  end
endmodule // scc_top_tb_top
`default_nettype wire
